/* hdl/irfei_top.sv */
`timescale 1ns/1ps
module irfei_top
  import irfei_pkg::*;
#(
  parameter int FAST_TOUT = FAST_TOUT_CYC,
  parameter int SLOW_BITS = SLOW_TOUT_BITS
)(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           cs_n,
  input  wire logic           rd_n,
  input  wire logic           wr_n,
  input  wire logic [3:0]     addr,
  input  wire logic [7:0]     data_in,
  output logic      [7:0]     data_out,
  output logic                data_oe,
  input  wire logic           power_down_n,
  output logic                interrupt_request_pin,
  input  wire logic           rx_enable,
  input  wire logic           tx_enable,
  input  wire irfei_xfer_type xfer_mode,
  input  wire logic [5:0]     fifo_count,
  input  wire irfei_core_type core,
  output irfei_op_type        op_mode,
  output logic                tx_halt,
  output logic                rx_drop_byte,
  output logic [5:0]          start_flag_count,
  output logic                start_count_reserved,
  output logic [4:0]          preamble_count,
  output logic [5:0]          start_flag_chips
);

  // two-stage synchronisers for the host pins
  logic [15:0] pin_meta_ff;
  logic [15:0] pin_sync_ff;
  logic        cs_s;
  logic        rd_s;
  logic        wr_s;
  logic        pwr_s;
  logic [3:0]  addr_s;
  logic [7:0]  din_s;
  logic        rd_act_ff;
  logic        wr_act_ff;
  logic        rd_start;
  logic        wr_end;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta_ff <= 16'h0000;
      pin_sync_ff <= 16'h0000;
      rd_act_ff   <= 1'b0;
      wr_act_ff   <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= {~cs_n, ~rd_n, ~wr_n, power_down_n, addr, data_in};
      pin_sync_ff <= pin_meta_ff;
      rd_act_ff   <= rd_s;
      wr_act_ff   <= wr_s;
    end
  end

  assign cs_s   = pin_sync_ff[15];
  assign rd_s   = pin_sync_ff[14] & cs_s;
  assign wr_s   = pin_sync_ff[13] & cs_s;
  assign pwr_s  = pin_sync_ff[12];
  assign addr_s = pin_sync_ff[11:8];
  assign din_s  = pin_sync_ff[7:0];

  // write taken at strobe release; host data must stand one clock past the strobe
  assign rd_start = rd_s & ~rd_act_ff;
  assign wr_end   = wr_act_ff & ~wr_s;

  always_comb
  begin
    if (!pwr_s)
      op_mode = OP_POWERDOWN;
    else if (rx_enable)
      op_mode = OP_RECEIVE;
    else if (tx_enable)
      op_mode = OP_TRANSMIT;
    else
      op_mode = OP_IDLE;
  end

  logic rx_mode;
  logic txi_mode;
  logic slow_kind;
  assign rx_mode   = (op_mode == OP_RECEIVE);
  assign txi_mode  = (op_mode == OP_TRANSMIT) || (op_mode == OP_IDLE);
  assign slow_kind = (xfer_mode == XFER_SIR) || (xfer_mode == XFER_SLOW);

  // writable registers
  logic [7:0] mask_ff;
  logic [7:0] thresh_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] size_l_ff;
  logic [7:0] size_h_ff;
  logic       irqpol_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_ff   <= RST_MASK;
      thresh_ff <= RST_THRESH;
      ctrl2_ff  <= RST_CTRL2;
      size_l_ff <= RST_SIZE_L;
      size_h_ff <= RST_SIZE_H;
      irqpol_ff <= RST_IRQPOL;
    end
    else if (wr_end)
    begin
      if (addr_s == ADDR_MASK)
        mask_ff <= din_s;
      else if (addr_s == ADDR_THRESH)
        thresh_ff <= din_s;
      else if (addr_s == ADDR_CTRL2)
        ctrl2_ff <= din_s;
      else if (addr_s == ADDR_SIZE_L)
        size_l_ff <= din_s;
      else if (addr_s == ADDR_SIZE_H)
        size_h_ff <= din_s;
      else if (addr_s == ADDR_IRQCFG)
        irqpol_ff <= din_s[IRQPOL_BIT];
    end
  end

  logic [5:0] tx_thr;
  logic [5:0] rx_thr;
  assign tx_thr = {1'b0, thresh_ff[TX_TH_LSB +: 4], 1'b0};
  assign rx_thr = {1'b0, thresh_ff[RX_TH_LSB +: 4], 1'b0};

  logic ev_read;
  assign ev_read = rd_start && (addr_s == ADDR_EVENT);

  logic [15:0] tout_cnt_ff;
  logic        tout_ff;
  logic        tout_hit;
  logic        tout_restart;
  assign tout_restart = core.rx_byte_stored || core.rx_data_read || (fifo_count == 6'h00);
  assign tout_hit = slow_kind ? (tout_cnt_ff >= 16'(SLOW_BITS))
                              : (tout_cnt_ff >= 16'(FAST_TOUT));

  always_ff @(posedge clk)
  begin
    if (rst || tout_restart || !rx_mode)
      tout_cnt_ff <= 16'h0000;
    else if (!tout_hit && (!slow_kind || core.bit_tick))
      tout_cnt_ff <= tout_cnt_ff + 16'h0001;
  end

  // timeout bit, cleared by data read, read wins as it also blocks the set
  always_ff @(posedge clk)
  begin
    if (rst)
      tout_ff <= 1'b0;
    else if (rx_mode && tout_hit && !tout_restart)
      tout_ff <= 1'b1;
    else if (core.rx_data_read || !rx_mode)
      tout_ff <= 1'b0;
  end

  // information byte count of current frame
  logic [15:0] frame_len_ff;
  logic        over_len;
  assign over_len = core.rx_info_byte && (frame_len_ff >= {size_h_ff, size_l_ff});

  always_ff @(posedge clk)
  begin
    if (rst || core.rx_frame_start)
      frame_len_ff <= 16'h0000;
    else if (core.rx_info_byte && (frame_len_ff != 16'hFFFF))
      frame_len_ff <= frame_len_ff + 16'h0001;
  end

  // drained event on the empty condition's rising edge
  logic empty_ff;
  logic drained_now;
  assign drained_now = (fifo_count == 6'h00) && core.tsr_empty;
  always_ff @(posedge clk)
  begin
    if (rst)
      empty_ff <= 1'b1;
    else
      empty_ff <= drained_now;
  end

  // full FIFO drops the completed byte
  assign rx_drop_byte = rx_mode && core.rx_byte_done && (fifo_count >= 6'(FIFO_DEPTH));

  // sticky flags ignore the mask; a set beats the read clear
  irfei_event_type flags_ff;
  irfei_event_type sets;
  always_comb
  begin
    sets                     = '0;
    sets.tx_drained_flag     = drained_now && !empty_ff;
    sets.frame_end_flag      = rx_mode && !slow_kind | (xfer_mode == XFER_SLOW)
                               ? rx_mode && core.rx_last_at_output : 1'b0;
    sets.over_length_flag    = rx_mode && over_len;
    sets.crc_error_flag      = rx_mode && core.crc_mismatch && !rx_drop_byte;
    sets.overrun_flag        = rx_drop_byte;
    // stop bit only in slow kinds
    sets.stop_bit_error_flag = rx_mode && slow_kind && core.stop_bit_missing;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      flags_ff <= '0;
    else
    begin
      // event bits set on their event
      flags_ff.tx_drained_flag     <= sets.tx_drained_flag | (flags_ff.tx_drained_flag & ~ev_read);
      flags_ff.frame_end_flag      <= sets.frame_end_flag | (flags_ff.frame_end_flag & ~ev_read);
      flags_ff.over_length_flag    <= sets.over_length_flag
                                      | (flags_ff.over_length_flag & ~ev_read);
      flags_ff.crc_error_flag      <= sets.crc_error_flag | (flags_ff.crc_error_flag & ~ev_read);
      flags_ff.overrun_flag        <= sets.overrun_flag | (flags_ff.overrun_flag & ~ev_read);
      flags_ff.stop_bit_error_flag <= sets.stop_bit_error_flag
                                      | (flags_ff.stop_bit_error_flag & ~ev_read);
      // transmit-low level flag, frozen outside transmit and idle
      if (txi_mode)
        flags_ff.tx_low_flag <= (fifo_count < tx_thr);
      flags_ff.rx_ready_flag <= rx_mode && ((fifo_count >= rx_thr)
                                || (tout_hit && !tout_restart) || tout_ff);
    end
  end

  // early drain in medium/fast halts transmit until enable drops
  always_ff @(posedge clk)
  begin
    if (rst || !tx_enable)
      tx_halt <= 1'b0;
    else if (sets.tx_drained_flag && core.frame_incomplete && !slow_kind)
      tx_halt <= 1'b1;
  end

  // any enabled flag raises the request; transmit-low only outside receive mode
  // transmit-low enable gated off here while in receive mode
  logic [7:0] eff_mask;
  logic       irq_any;
  assign eff_mask = {mask_ff[7], mask_ff[6] & ~rx_mode, mask_ff[5:0]};
  assign irq_any  = |(flags_ff & eff_mask);

  always_ff @(posedge clk)
  begin
    if (rst)
      interrupt_request_pin <= 1'b1;
    else
      interrupt_request_pin <= irqpol_ff ? irq_any : ~irq_any;
  end

  // register read port, data latched as the read starts
  always_ff @(posedge clk)
  begin
    if (rst)
      data_out <= 8'h00;
    else if (rd_start)
    begin
      if (addr_s == ADDR_MASK)
        data_out <= mask_ff;
      else if (addr_s == ADDR_EVENT)
        data_out <= flags_ff;
      else if (addr_s == ADDR_LINE)
        data_out <= {fifo_count, 1'b0, tout_ff};
      else if (addr_s == ADDR_CTRL2)
        data_out <= ctrl2_ff;
      else if (addr_s == ADDR_THRESH)
        data_out <= thresh_ff;
      else if (addr_s == ADDR_SIZE_L)
        data_out <= size_l_ff;
      else if (addr_s == ADDR_SIZE_H)
        data_out <= size_h_ff;
      else if (addr_s == ADDR_IRQCFG)
        data_out <= {7'h00, irqpol_ff};
      else
        data_out <= 8'h00;
    end
  end

  assign data_oe = rd_act_ff;

  logic [3:0] start_code;
  assign start_code = ctrl2_ff[3:0];

  always_comb
  begin
    start_flag_count     = 6'h00;
    start_count_reserved = 1'b0;
    case (xfer_mode)
      XFER_SLOW:
        case (start_code)
          4'h0: start_flag_count = 6'h01;
          4'h1: start_flag_count = 6'h02;
          4'h2: start_flag_count = 6'h03;
          4'h3: start_flag_count = 6'h04;
          4'h4: start_flag_count = 6'h05;
          4'h5: start_flag_count = 6'h07;
          4'h6: start_flag_count = 6'h09;
          4'h7: start_flag_count = 6'h0D;
          4'h8: start_flag_count = 6'h11;
          4'h9: start_flag_count = 6'h19;
          4'hA: start_flag_count = 6'h31;
          default: start_count_reserved = 1'b1;
        endcase
      XFER_MIR:
        case (start_code)
          4'h0: start_flag_count = 6'h02;
          4'h1: start_flag_count = 6'h03;
          4'h2: start_flag_count = 6'h04;
          4'h3: start_flag_count = 6'h05;
          4'h4: start_flag_count = 6'h08;
          4'h5: start_flag_count = 6'h0C;
          4'h6: start_flag_count = 6'h10;
          4'h7: start_flag_count = 6'h18;
          default: start_count_reserved = 1'b1;
        endcase
      XFER_FIR:
        start_flag_count = 6'h01;
      default:
        start_flag_count = 6'h00;
    endcase
  end

  // fixed fast-mode preamble and start flag
  assign preamble_count   = (xfer_mode == XFER_FIR) ? 5'(FIR_PREAMBLES) : 5'h00;
  assign start_flag_chips = (xfer_mode == XFER_FIR) ? 6'(FIR_START_CHIPS) : 6'h00;

endmodule : irfei_top

/* shared/irfei_pkg.sv */
package irfei_pkg;

  // register offsets on the 4-bit address port
  localparam logic [3:0] ADDR_MASK   = 4'h1;
  localparam logic [3:0] ADDR_EVENT  = 4'h2;
  localparam logic [3:0] ADDR_LINE   = 4'h3;
  localparam logic [3:0] ADDR_CTRL2  = 4'h5;
  localparam logic [3:0] ADDR_THRESH = 4'h8;
  localparam logic [3:0] ADDR_SIZE_L = 4'hB;
  localparam logic [3:0] ADDR_SIZE_H = 4'hC;
  localparam logic [3:0] ADDR_IRQCFG = 4'hD;

  // reset values
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_CTRL2  = 8'h00;
  localparam logic [7:0] RST_SIZE_L = 8'h00;
  localparam logic [7:0] RST_SIZE_H = 8'h00;
  localparam logic       RST_IRQPOL = 1'b0;

  // field positions
  localparam int TX_TH_LSB  = 0;
  localparam int RX_TH_LSB  = 4;
  localparam int TOUT_BIT   = 0;
  localparam int LEVEL_LSB  = 2;
  localparam int IRQPOL_BIT = 0;

  // timing
  localparam int  CLK_HZ           = 40_000_000;
  localparam real FAST_TOUT_US     = 69.5;
  localparam int  FAST_TOUT_CYC    = int'(FAST_TOUT_US * CLK_HZ / 1.0e6);
  localparam int  SLOW_TOUT_BITS   = 4 * 8;
  localparam int  FIR_PREAMBLES    = 16;
  localparam int  FIR_PREAMBLE_CHP = 16;
  localparam int  FIR_START_CHIPS  = 32;
  localparam int  FIFO_DEPTH       = 32;

  typedef enum logic [1:0] {
    XFER_SIR  = 2'b00,
    XFER_SLOW = 2'b01,
    XFER_MIR  = 2'b10,
    XFER_FIR  = 2'b11
  } irfei_xfer_type;

  typedef enum logic [1:0] {
    OP_POWERDOWN = 2'b00,
    OP_IDLE      = 2'b01,
    OP_TRANSMIT  = 2'b10,
    OP_RECEIVE   = 2'b11
  } irfei_op_type;

  typedef struct packed {
    logic tx_drained_flag;
    logic tx_low_flag;
    logic rx_ready_flag;
    logic frame_end_flag;
    logic over_length_flag;
    logic crc_error_flag;
    logic overrun_flag;
    logic stop_bit_error_flag;
  } irfei_event_type;

  // one-cycle strobes and levels (tsr_empty, frame_incomplete) from the datapath of the controller
  typedef struct packed {
    logic tsr_empty;
    logic rx_byte_done;
    logic rx_byte_stored;
    logic rx_data_read;
    logic rx_info_byte;
    logic rx_frame_start;
    logic rx_last_at_output;
    logic crc_mismatch;
    logic stop_bit_missing;
    logic frame_incomplete;
    logic bit_tick;
  } irfei_core_type;

endpackage : irfei_pkg

/* test/irfei_chk.sv */
`timescale 1ns/1ps
module irfei_chk
  import irfei_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           cs_n,
  input wire logic           rd_n,
  input wire logic           data_oe,
  input wire logic           power_down_n,
  input wire logic           rx_enable,
  input wire logic           tx_enable,
  input wire irfei_xfer_type xfer_mode,
  input wire logic [5:0]     fifo_count,
  input wire irfei_core_type core,
  input wire irfei_op_type   op_mode,
  input wire logic           tx_halt,
  input wire logic           rx_drop_byte,
  input wire logic [5:0]     start_flag_count,
  input wire logic           start_count_reserved,
  input wire logic [4:0]     preamble_count,
  input wire logic [5:0]     start_flag_chips
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_mode_select:
    assert property (power_down_n [*5] |-> op_mode == (rx_enable ? OP_RECEIVE :
      (tx_enable ? OP_TRANSMIT : OP_IDLE))) else $error("operating mode wrong");
  chk_power_down:
    assert property (!power_down_n [*4] |-> op_mode == OP_POWERDOWN)
    else $error("power-down not entered");
  chk_fir_preamble:
    assert property (xfer_mode == XFER_FIR |-> preamble_count == 5'h10
      && start_flag_chips == 6'h20) else $error("fast preamble wrong");
  chk_sir_no_flags:
    assert property (xfer_mode == XFER_SIR |-> start_flag_count == 6'h00
      && !start_count_reserved) else $error("start flags in plain mode");
  chk_overrun_drop:
    assert property (op_mode == OP_RECEIVE && core.rx_byte_done && fifo_count == 6'h20
      |-> rx_drop_byte) else $error("overrun byte not dropped");
  chk_drop_cause:
    assert property (rx_drop_byte |-> core.rx_byte_done && fifo_count == 6'h20)
    else $error("byte dropped without overrun");
  chk_halt_release:
    assert property (!tx_enable |=> !tx_halt) else $error("halt kept after disable");
  chk_halt_cause:
    assert property ($rose(tx_halt) |-> $past(xfer_mode[1]) && $past(core.frame_incomplete))
    else $error("halt without fast-mode fragment");
  chk_read_drive:
    assert property ((!cs_n && !rd_n) [*5] |-> data_oe) else $error("read not driven");
  chk_read_release:
    assert property (rd_n [*5] |-> !data_oe) else $error("bus driven while idle");
endmodule : irfei_chk

bind irfei_top irfei_chk i_chk (
  .clk, .rst, .cs_n, .rd_n, .data_oe, .power_down_n, .rx_enable, .tx_enable,
  .xfer_mode, .fifo_count, .core, .op_mode, .tx_halt, .rx_drop_byte,
  .start_flag_count, .start_count_reserved, .preamble_count, .start_flag_chips
);

/* test/irfei_host.sv */
`timescale 1ns/1ps
module irfei_host (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [3:0]      addr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out
);
  initial
  begin
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 4'h0;
    data_in = 8'h00;
  end

  // strobes held five cycles each way, above the three-cycle synchroniser floor
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk);
    addr = a;
    data_in = d;
    {cs_n, rd_n, wr_n} = {1'b0, w, !w};
    repeat (5) @(negedge clk);
    q = data_out;
    {cs_n, rd_n, wr_n} = 3'h7;
    // data held one clock past the strobe, as the release is sampled with it
    @(negedge clk);
    // released bus shows inverted data so a stale value cannot be mistaken
    data_in = ~d;
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : irfei_host

/* test/irfei_tb_top.sv */
`timescale 1ns/1ps
module irfei_tb_top;
  import irfei_pkg::*;
  logic           clk, rst, cs_n, rd_n, wr_n, data_oe, power_down_n;
  logic           interrupt_request_pin, rx_enable, tx_enable, tx_halt;
  logic           rx_drop_byte, start_count_reserved;
  logic [3:0]     addr;
  logic [7:0]     data_in, data_out;
  logic [5:0]     fifo_count, start_flag_count, start_flag_chips;
  logic [4:0]     preamble_count;
  irfei_xfer_type xfer_mode;
  irfei_core_type core;
  irfei_op_type   op_mode;
  int             n_fail = 0;
  int             check_count = 0;
  localparam logic [10:0] cp [6] = '{11'h010, 11'h008, 11'h004, 11'h040, 11'h040, 11'h040};
  localparam logic [7:0]  ce [6] = '{8'h50, 8'h44, 8'h41, 8'h40, 8'h40, 8'h48};
  localparam logic [5:0]  sf [2][12] = '{
    '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09, 6'h0D, 6'h11, 6'h19, 6'h31, 6'h00},
    '{6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h00, 6'h00, 6'h00, 6'h00}};

  irfei_top #(.FAST_TOUT(20)) i_dut (
    .clk, .rst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
    .power_down_n, .interrupt_request_pin, .rx_enable, .tx_enable, .xfer_mode,
    .fifo_count, .core, .op_mode, .tx_halt, .rx_drop_byte, .start_flag_count,
    .start_count_reserved, .preamble_count, .start_flag_chips);
  irfei_host i_host (.clk, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // strobes are two cycles apart so each counts as a separate event
  task automatic pulse(input logic [10:0] p, input int n);
    repeat (n)
    begin
      @(negedge clk);
      core = core | p;
      @(negedge clk);
      core = core & ~p;
    end
  endtask : pulse

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    {rst, power_down_n, rx_enable, tx_enable} = 4'hC;
    xfer_mode = XFER_SLOW;
    fifo_count = 6'h00;
    core = '0;
    cyc(10);
    rst = 1'b0;
    cyc(3);
    chk("irq", 8'h01, interrupt_request_pin);
    rd(ADDR_MASK, RST_MASK, "mask");
    rd(4'h7, 8'h00, "unmapped");
    wr(ADDR_THRESH, 8'h12);
    fifo_count = 6'h03;
    cyc(4);
    chk("irq", 8'h01, interrupt_request_pin);
    rd(ADDR_EVENT, 8'h40, "events");
    wr(ADDR_MASK, 8'h40);
    chk("irq", 8'h00, interrupt_request_pin);
    fifo_count = 6'h04;
    cyc(4);
    chk("irq", 8'h01, interrupt_request_pin);
    rd(ADDR_EVENT, 8'h00, "events");
    wr(ADDR_IRQCFG, 8'h01);
    fifo_count = 6'h03;
    cyc(4);
    chk("irq", 8'h01, interrupt_request_pin);
    wr(ADDR_IRQCFG, 8'h00);
    fifo_count = 6'h00;
    core.tsr_empty = 1'b1;
    cyc(4);
    rd(ADDR_EVENT, 8'hC0, "events");
    rd(ADDR_EVENT, 8'h40, "events");
    wr(ADDR_MASK, 8'hFF);
    rx_enable = 1'b1;
    cyc(4);
    chk("irq", 8'h01, interrupt_request_pin);
    rd(ADDR_EVENT, 8'h40, "events");
    fifo_count = 6'h02;
    cyc(4);
    chk("irq", 8'h00, interrupt_request_pin);
    rd(ADDR_EVENT, 8'h60, "events");
    fifo_count = 6'h01;
    cyc(4);
    rd(ADDR_EVENT, 8'h40, "events");
    wr(ADDR_SIZE_L, 8'h02);
    pulse(11'h020, 1);
    for (int i = 0; i < 6; i++)
    begin
      pulse(cp[i], 1);
      rd(ADDR_EVENT, ce[i], "events");
    end
    fifo_count = 6'h20;
    pulse(11'h208, 1);
    rd(ADDR_EVENT, 8'h62, "events");
    xfer_mode = XFER_SIR;
    fifo_count = 6'h01;
    pulse(11'h100, 1);
    pulse(11'h001, 31);
    rd(ADDR_LINE, 8'h04, "line");
    pulse(11'h001, 1);
    rd(ADDR_LINE, 8'h05, "line");
    rd(ADDR_EVENT, 8'h60, "events");
    pulse(11'h080, 1);
    rd(ADDR_LINE, 8'h04, "line");
    rd(ADDR_EVENT, 8'h40, "events");
    xfer_mode = XFER_MIR;
    pulse(11'h100, 1);
    rd(ADDR_LINE, 8'h04, "line");
    cyc(20);
    rd(ADDR_LINE, 8'h05, "line");
    pulse(11'h080, 1);
    fifo_count = 6'h02;
    rx_enable = 1'b0;
    cyc(4);
    rd(ADDR_EVENT, 8'h40, "events");
    power_down_n = 1'b0;
    cyc(4);
    chk("mode", OP_POWERDOWN, op_mode);
    power_down_n = 1'b1;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 12; i++)
      begin
        xfer_mode = (m == 1) ? XFER_MIR : XFER_SLOW;
        wr(ADDR_CTRL2, 8'(i));
        if (sf[m][i] != 6'h00)
          chk("count", sf[m][i], start_flag_count);
        chk("reserved", sf[m][i] == 6'h00, start_count_reserved);
      end
    xfer_mode = XFER_FIR;
    cyc(1);
    chk("preamble", 8'h10, preamble_count);
    chk("chips", 8'h20, start_flag_chips);
    xfer_mode = XFER_MIR;
    fifo_count = 6'h00;
    core.tsr_empty = 1'b0;
    core.frame_incomplete = 1'b1;
    tx_enable = 1'b1;
    cyc(3);
    core.tsr_empty = 1'b1;
    cyc(4);
    chk("halt", 8'h01, tx_halt);
    tx_enable = 1'b0;
    cyc(2);
    chk("halt", 8'h00, tx_halt);
    stop_test();
  end
endmodule : irfei_tb_top
